//--- fsp_cfg.svh
// Constants for the flash self-programming sequencer
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// Flash geometry and pointer mapping
`define FSP_PC_W 13
`define FSP_PAGE_W 7
`define FSP_WORD_W 6
`define FSP_Z_PAGE_HI 13
`define FSP_Z_PAGE_LO 7
`define FSP_Z_WORD_HI 6
`define FSP_Z_WORD_LO 1
`define FSP_Z_PC_HI 13
`define FSP_Z_BYTE 0
`define FSP_PAGE_WORDS 64
`define FSP_LAST_WORD 6'h3f
`define FSP_ERASED_WORD 16'hffff

// Region split
`define FSP_RWW_LAST 13'h1bff
`define FSP_NO_READ_WHILE_WRITE_REGION_FIRST 13'h1c00
`define FSP_NO_READ_WHILE_WRITE_REGION_LAST 13'h1fff
`define FSP_NO_READ_WHILE_WRITE_REGION_PAGE 7'h70

// Boot section start per size code
`define FSP_BOOT_START_11 13'h1f80
`define FSP_BOOT_START_10 13'h1f00
`define FSP_BOOT_START_01 13'h1e00
`define FSP_BOOT_START_00 13'h1c00

// Register offsets
`define FSP_A_CTRL 3'h0
`define FSP_A_STAT 3'h1
`define FSP_A_BOOT_LO 3'h2
`define FSP_A_BOOT_HI 3'h3

// Control register bit positions
`define FSP_B_EN 0
`define FSP_B_ERASE 1
`define FSP_B_WRITE 2
`define FSP_B_LOCK 3
`define FSP_B_REEN 4
`define FSP_B_BUSY 6
`define FSP_CTRL_RST 8'h00

// Store must follow the control write within this many cycles
`define FSP_STORE_WIN 3'h4

// Operation time, measured in calibrated RC oscillator ticks
`define FSP_OP_MIN_US 3700
`define FSP_OP_MAX_US 4500
`define FSP_RC_KHZ 1000
`define FSP_OP_MIN_TICKS ((`FSP_OP_MIN_US * `FSP_RC_KHZ + 999) / 1000)
`define FSP_OP_MAX_TICKS ((`FSP_OP_MAX_US * `FSP_RC_KHZ) / 1000)
`define FSP_OP_TICKS (`FSP_OP_MIN_TICKS + 1)

`endif

//--- fsp_pkg.sv
// Types shared by the flash self-programming sequencer
package fsp_pkg;
`include "fsp_cfg.svh"

	typedef enum logic [2:0] {
		FSP_ST_IDLE = 3'b001,
		FSP_ST_STREAM = 3'b010,
		FSP_ST_WAIT = 3'b100
	} fsp_state_t;

	typedef struct packed {
		logic [15:0] z;
		logic [15:0] data;
	} fsp_store_t;

	typedef struct packed {
		logic [`FSP_PC_W-1:0] addr;
		logic hi;
	} fsp_load_t;

	typedef struct packed {
		logic erase;
		logic write;
		logic lock;
		logic [`FSP_PC_W-1:0] addr;
		logic [15:0] data;
	} fsp_flash_req_t;

endpackage : fsp_pkg

//--- fsp_page_buf.sv
// Temporary page buffer with registered read data
`timescale 1ns/10ps
module fsp_page_buf #(
	parameter int DW = 16,
	parameter int AW = 6
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [DW-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [DW-1:0] o_rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge i_clk_sys) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule : fsp_page_buf

//--- fsp_self_prog.sv
// Flash self-programming sequencer: command arming, timing, region guard
`timescale 1ns/10ps
`include "fsp_cfg.svh"
module fsp_self_prog #(
	parameter int OP_TICKS = `FSP_OP_TICKS
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_rst_por,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_store,
	input wire fsp_pkg::fsp_store_t i_store_data,
	input wire logic i_load,
	input wire logic [15:0] i_load_z,
	output fsp_pkg::fsp_load_t o_load,
	input wire logic i_rc_tick,
	input wire logic i_sleep_pd,
	input wire logic i_eeprom_write_active,
	input wire logic [1:0] i_boot_size,
	output logic [`FSP_PC_W-1:0] o_boot_start,
	output logic [`FSP_PC_W-1:0] o_app_end,
	input wire logic [`FSP_PC_W-1:0] i_fetch_addr,
	output logic o_fetch_block,
	output logic o_cpu_halt,
	output fsp_pkg::fsp_flash_req_t o_flash,
	output logic o_busy
);
	import fsp_pkg::*;

	localparam int TW = $clog2(OP_TICKS + 1);

	function automatic logic [`FSP_PC_W-1:0] boot_start(
		input logic [1:0] code);
		logic [`FSP_PC_W-1:0] s;
		s = `FSP_BOOT_START_00;
		case (code)
			2'b11: s = `FSP_BOOT_START_11;
			2'b10: s = `FSP_BOOT_START_10;
			2'b01: s = `FSP_BOOT_START_01;
			default: s = `FSP_BOOT_START_00;
		endcase
		return s;
	endfunction : boot_start

	function automatic logic in_rww(input logic [`FSP_PC_W-1:0] a);
		return a <= `FSP_RWW_LAST;
	endfunction : in_rww

	// Armed command, kept in the system reset domain
	logic armed;
	logic arm_erase;
	logic arm_write;
	logic arm_lock;
	logic arm_reen;
	logic [2:0] win_cnt;

	// Operation state survives system reset; only power-on clears it
	fsp_state_t state;
	logic [TW-1:0] tick_cnt;
	logic op_no_read_while_write_region;
	logic region_busy_flag;
	logic [`FSP_PAGE_W-1:0] op_page;
	logic [`FSP_WORD_W-1:0] stream_idx;
	logic stream_v;
	logic stream_ok;
	logic [`FSP_WORD_W-1:0] stream_word;
	logic op_kind_write;

	logic [`FSP_PAGE_WORDS-1:0] word_loaded;
	logic [15:0] buf_rdata;
	logic blocked;
	logic store_ok;
	logic op_active;
	logic start_erase;
	logic start_write;
	logic start_lock;
	logic do_fill;
	logic do_reen;
	logic op_done;
	logic [`FSP_PAGE_W-1:0] store_page;
	logic [`FSP_WORD_W-1:0] store_word;
	logic [7:0] next_rdata;

	assign op_active = (state != FSP_ST_IDLE);
	// Sleep and EEPROM writes hold off both the control write and the store
	assign blocked = i_sleep_pd | i_eeprom_write_active;
	assign store_ok = i_store & armed & ~blocked & ~op_active;
	// Pointer bits 15:14 and bit 0 never reach the flash address
	assign store_page = i_store_data.z[`FSP_Z_PAGE_HI:`FSP_Z_PAGE_LO];
	assign store_word = i_store_data.z[`FSP_Z_WORD_HI:`FSP_Z_WORD_LO];
	assign start_erase = store_ok & arm_erase;
	assign start_write = store_ok & arm_write & ~arm_erase;
	assign start_lock = store_ok & arm_lock & ~arm_erase & ~arm_write;
	assign do_reen = store_ok & arm_reen & ~arm_erase & ~arm_write & ~arm_lock;
	assign do_fill = store_ok & ~arm_erase & ~arm_write & ~arm_lock & ~arm_reen;
	assign op_done = (state == FSP_ST_WAIT) && (tick_cnt == TW'(OP_TICKS));

	// Arm on a control write; lapse after the store window or on the store
	// A lapsed window drops the command quietly; software sees enable low
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			armed <= 1'b0;
			arm_erase <= 1'b0;
			arm_write <= 1'b0;
			arm_lock <= 1'b0;
			arm_reen <= 1'b0;
			win_cnt <= 3'h0;
		end else if (i_wr && i_addr == `FSP_A_CTRL && !blocked &&
			!op_active && i_wdata[`FSP_B_EN]) begin
			armed <= 1'b1;
			arm_erase <= i_wdata[`FSP_B_ERASE];
			arm_write <= i_wdata[`FSP_B_WRITE];
			arm_lock <= i_wdata[`FSP_B_LOCK];
			arm_reen <= i_wdata[`FSP_B_REEN];
			win_cnt <= `FSP_STORE_WIN;
		end else if (store_ok || (armed && win_cnt == 3'h1)) begin
			armed <= 1'b0;
			arm_erase <= 1'b0;
			arm_write <= 1'b0;
			arm_lock <= 1'b0;
			arm_reen <= 1'b0;
			win_cnt <= 3'h0;
		end else if (armed) begin
			win_cnt <= win_cnt - 3'h1;
		end
	end

	// Operation sequencer; a system reset does not abort it
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por) begin
			state <= FSP_ST_IDLE;
			op_page <= '0;
			op_no_read_while_write_region <= 1'b0;
			op_kind_write <= 1'b0;
			stream_idx <= '0;
		end else begin
			case (state)
				FSP_ST_IDLE: begin
					if (start_erase || start_write || start_lock) begin
						op_page <= store_page;
						op_kind_write <= start_write;
						op_no_read_while_write_region <= ~start_lock &
							(store_page >= `FSP_NO_READ_WHILE_WRITE_REGION_PAGE);
						stream_idx <= '0;
						state <= start_write ? FSP_ST_STREAM : FSP_ST_WAIT;
					end
				end
				FSP_ST_STREAM: begin
					stream_idx <= stream_idx + 1'b1;
					if (stream_idx == `FSP_LAST_WORD) begin
						state <= FSP_ST_WAIT;
					end
				end
				FSP_ST_WAIT: begin
					if (op_done) begin
						state <= FSP_ST_IDLE;
					end
				end
				default: state <= FSP_ST_IDLE;
			endcase
		end
	end

	// Timer counts RC oscillator ticks from the start of the operation
	// It saturates at the limit, so a long page stream cannot wrap it
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por) begin
			tick_cnt <= '0;
		end else if (!op_active) begin
			tick_cnt <= '0;
		end else if (i_rc_tick && tick_cnt != TW'(OP_TICKS)) begin
			tick_cnt <= TW'(tick_cnt + 1'b1);
		end
	end

	// Busy flag: set by an erase or write into the lower region, cleared
	// only by a re-enable store once the operation is over
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por) begin
			region_busy_flag <= 1'b0;
		end else if ((start_erase || start_write) &&
			store_page < `FSP_NO_READ_WHILE_WRITE_REGION_PAGE) begin
			region_busy_flag <= 1'b1;
		end else if (do_reen) begin
			region_busy_flag <= 1'b0;
		end
	end

	// Which buffer words hold data; erased by power-on, write end, re-enable.
	// Kept out of the system reset domain: a reset in the middle of a page
	// write must not turn the rest of the page into erased words.
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por) begin
			word_loaded <= '0;
		end else if (do_reen || (op_done && op_kind_write)) begin
			word_loaded <= '0;
		end else if (do_fill) begin
			word_loaded[store_word] <= 1'b1;
		end
	end

	// Each word may be written once between erasures of the buffer
	// Its read register follows power-on reset so a running stream survives
	fsp_page_buf #(
		.DW(16),
		.AW(`FSP_WORD_W)
	) u_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst_por),
		.i_we(do_fill && !word_loaded[store_word]),
		.i_waddr(store_word),
		.i_wdata(i_store_data.data),
		.i_raddr(stream_idx),
		.o_rdata(buf_rdata)
	);

	// Align stream bookkeeping with the registered buffer read
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por) begin
			stream_v <= 1'b0;
			stream_ok <= 1'b0;
			stream_word <= '0;
		end else begin
			stream_v <= (state == FSP_ST_STREAM);
			stream_ok <= word_loaded[stream_idx];
			stream_word <= stream_idx;
		end
	end

	// Requests to the flash array, one cycle each
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por) begin
			o_flash <= '0;
		end else begin
			o_flash.erase <= start_erase;
			o_flash.lock <= start_lock;
			o_flash.write <= stream_v;
			if (start_erase) begin
				o_flash.addr <= {store_page, `FSP_WORD_W'(0)};
				o_flash.data <= `FSP_ERASED_WORD;
			end else if (start_lock) begin
				o_flash.addr <= '0;
				o_flash.data <= i_store_data.data;
			end else if (stream_v) begin
				o_flash.addr <= {op_page, stream_word};
				// Words never loaded stay erased
				o_flash.data <= stream_ok ? buf_rdata : `FSP_ERASED_WORD;
			end
		end
	end

	// Fetch guard and core halt
	// The core halts only for the upper region; the lower one is guarded by
	// the fetch block so code up there keeps running
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por) begin
			o_cpu_halt <= 1'b0;
		end else begin
			o_cpu_halt <= (start_erase || start_write) ?
				(store_page >= `FSP_NO_READ_WHILE_WRITE_REGION_PAGE) :
				(op_active && op_no_read_while_write_region && !op_done);
		end
	end
	assign o_fetch_block = region_busy_flag & in_rww(i_fetch_addr);
	assign o_busy = op_active;

	// Load addressing: word from pointer 13:1, byte from bit 0
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_load <= '0;
		end else if (i_load) begin
			o_load.addr <= i_load_z[`FSP_Z_PC_HI:`FSP_Z_WORD_LO];
			o_load.hi <= i_load_z[`FSP_Z_BYTE];
		end
	end

	// Boot section boundaries from the size code
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_boot_start <= `FSP_BOOT_START_00;
			o_app_end <= `FSP_RWW_LAST;
		end else begin
			o_boot_start <= boot_start(i_boot_size);
			o_app_end <= boot_start(i_boot_size) - 1'b1;
		end
	end

	// Register read, answered in the next cycle
	always_comb begin
		next_rdata = 8'h00;
		if (i_addr == `FSP_A_CTRL) begin
			next_rdata[`FSP_B_EN] = armed | op_active;
			next_rdata[`FSP_B_ERASE] = arm_erase;
			next_rdata[`FSP_B_WRITE] = arm_write;
			next_rdata[`FSP_B_LOCK] = arm_lock;
			next_rdata[`FSP_B_REEN] = arm_reen;
			next_rdata[`FSP_B_BUSY] = region_busy_flag;
		end else if (i_addr == `FSP_A_STAT) begin
			next_rdata = {4'h0, i_boot_size, o_cpu_halt, op_active};
		end else if (i_addr == `FSP_A_BOOT_LO) begin
			next_rdata = o_boot_start[7:0];
		end else if (i_addr == `FSP_A_BOOT_HI) begin
			next_rdata = {3'h0, o_boot_start[`FSP_PC_W-1:8]};
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule : fsp_self_prog

//--- fsp_self_prog_props.sv
// Port-level checker for the flash self-programming sequencer
`timescale 1ns/10ps
module fsp_self_prog_props #(
	parameter int OP_TICKS = 3701
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_rst_por,
	input wire logic i_store,
	input wire fsp_pkg::fsp_store_t i_store_data,
	input wire logic i_load,
	input wire logic [15:0] i_load_z,
	input wire fsp_pkg::fsp_load_t o_load,
	input wire logic i_rc_tick,
	input wire logic i_sleep_pd,
	input wire logic i_eeprom_write_active,
	input wire logic [1:0] i_boot_size,
	input wire logic [12:0] o_boot_start,
	input wire logic [12:0] o_app_end,
	input wire logic [12:0] i_fetch_addr,
	input wire logic o_fetch_block,
	input wire logic o_cpu_halt,
	input wire fsp_pkg::fsp_flash_req_t o_flash,
	input wire logic o_busy
);
	import fsp_pkg::*;
	logic [15:0] tick_cnt;
	// Only power-on reset clears it: a system reset must not cut an operation
	always_ff @(posedge i_clk_sys or posedge i_rst_por) begin
		if (i_rst_por)
			tick_cnt <= 16'h0;
		else if (!o_busy)
			tick_cnt <= 16'h0;
		else if (i_rc_tick)
			tick_cnt <= tick_cnt + 16'h1;
	end
	sequence s_next_word;
		o_flash.write && o_flash.addr == $past(o_flash.addr) + 13'h1;
	endsequence
	property p_boot;
		@(posedge i_clk_sys) disable iff (i_rst) !$past(i_rst) |->
			o_boot_start == 14'h2000 - (14'h80 << ~$past(i_boot_size));
	endproperty
	a_boot: assert property (p_boot) else $error("boot start");
	property p_app_end;
		@(posedge i_clk_sys) disable iff (i_rst) o_app_end == o_boot_start - 13'h1;
	endproperty
	a_app_end: assert property (p_app_end) else $error("app end");
	property p_erase_page;
		@(posedge i_clk_sys) disable iff (i_rst_por) o_flash.erase |->
			o_flash.addr == {$past(i_store_data.z[13:7]), 6'h0};
	endproperty
	a_erase_page: assert property (p_erase_page) else $error("erase page");
	property p_load;
		@(posedge i_clk_sys) disable iff (i_rst) i_load |=> o_load == $past(i_load_z[13:0]);
	endproperty
	a_load: assert property (p_load) else $error("load map");
	property p_tick_len;
		@(posedge i_clk_sys) disable iff (i_rst_por) $fell(o_busy) |->
			tick_cnt >= OP_TICKS - 1 && tick_cnt <= OP_TICKS;
	endproperty
	a_tick_len: assert property (p_tick_len) else $error("op length");
	property p_tick_max;
		@(posedge i_clk_sys) disable iff (i_rst_por) o_busy |-> tick_cnt <= OP_TICKS;
	endproperty
	a_tick_max: assert property (p_tick_max) else $error("op too long");
	property p_burst_start;
		@(posedge i_clk_sys) disable iff (i_rst_por)
			$rose(o_flash.write) |-> o_flash.addr[5:0] == 6'h0 && o_busy;
	endproperty
	a_burst_start: assert property (p_burst_start) else $error("burst start");
	property p_burst_step;
		@(posedge i_clk_sys) disable iff (i_rst_por)
			o_flash.write && o_flash.addr[5:0] != 6'h3f |=> s_next_word;
	endproperty
	a_burst_step: assert property (p_burst_step) else $error("burst step");
	property p_halt;
		@(posedge i_clk_sys) disable iff (i_rst_por) o_cpu_halt |-> o_busy || $past(o_busy);
	endproperty
	a_halt: assert property (p_halt) else $error("halt");
	property p_fetch;
		@(posedge i_clk_sys) disable iff (i_rst_por) o_fetch_block |-> i_fetch_addr <= 13'h1bff;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch block");
	property p_blocked;
		@(posedge i_clk_sys) disable iff (i_rst_por)
			i_store && (i_sleep_pd || i_eeprom_write_active) && !o_busy |=> !o_busy;
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked store");
endmodule : fsp_self_prog_props

bind fsp_self_prog fsp_self_prog_props #(.OP_TICKS(OP_TICKS)) u_props (.i_clk_sys,
	.i_rst, .i_rst_por, .i_store, .i_store_data, .i_load, .i_load_z, .o_load,
	.i_rc_tick, .i_sleep_pd, .i_eeprom_write_active, .i_boot_size, .o_boot_start,
	.o_app_end, .i_fetch_addr, .o_fetch_block, .o_cpu_halt, .o_flash, .o_busy);

//--- fsp_core_model.sv
// Core model: timed program store after a control write, plus RC ticks
`timescale 1ns/10ps
module fsp_core_model (
	input wire logic i_clk_sys,
	input wire logic i_go,
	input wire logic [2:0] i_lag,
	input wire logic [15:0] i_z,
	input wire logic [15:0] i_data,
	output logic o_store,
	output fsp_pkg::fsp_store_t o_store_data,
	output logic o_rc_tick
);
	import fsp_pkg::*;
	logic [3:0] div = 4'h0;
	initial begin
		o_store = 1'b0;
		o_store_data = '0;
		o_rc_tick = 1'b0;
	end
	// Slow oscillator seen as one pulse every sixteen system cycles
	always @(posedge i_clk_sys) begin
		div <= div + 4'h1;
		o_rc_tick <= (div == 4'hf);
	end
	// Store lands i_lag cycles after the control write; five is too late
	always @(posedge i_clk_sys) begin
		if (i_go) begin
			repeat (i_lag - 3'h1) @(posedge i_clk_sys);
			o_store <= 1'b1;
			o_store_data <= {i_z, i_data};
			@(posedge i_clk_sys);
			o_store <= 1'b0;
			o_store_data <= ~o_store_data;
		end
	end
endmodule : fsp_core_model

//--- tb_fsp_self_prog.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
module tb_fsp_self_prog;
	import fsp_pkg::*;
	logic clk = 0, rst = 1, por = 1, wr = 0, rd = 0, ld = 0, hseen = 0;
	logic sl = 0, ee = 0, go = 0, st, tick, fb, halt, busy;
	logic [2:0] a = 0, lag = 1;
	logic [7:0] wd = 0, rdata, rv;
	logic [15:0] lz = 0, z = 0, dat = 0, lastd, lockd;
	logic [1:0] bs = 0;
	logic [12:0] bst, aend, fa = 0, eaddr;
	fsp_store_t sd;
	fsp_load_t lo;
	fsp_flash_req_t fl;
	int err_count = 0, num_checks = 0, wcnt = 0, cyc = 0;
	always #20 clk = ~clk;
	fsp_self_prog #(.OP_TICKS(8)) uut (.i_clk_sys(clk), .i_rst(rst),
		.i_rst_por(por), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_store(st), .i_store_data(sd), .i_load(ld),
		.i_load_z(lz), .o_load(lo), .i_rc_tick(tick), .i_sleep_pd(sl),
		.i_eeprom_write_active(ee), .i_boot_size(bs), .o_boot_start(bst),
		.o_app_end(aend), .i_fetch_addr(fa), .o_fetch_block(fb),
		.o_cpu_halt(halt), .o_flash(fl), .o_busy(busy));
	fsp_core_model core (.i_clk_sys(clk), .i_go(go), .i_lag(lag), .i_z(z),
		.i_data(dat), .o_store(st), .o_store_data(sd), .o_rc_tick(tick));
	task automatic conclude;
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [15:0] s, e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wrr(input logic [2:0] ad, input logic [7:0] d, input logic g);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1;
		go <= g;
		@(posedge clk);
		wr <= 0;
		go <= 0;
	endtask : wrr
	task automatic rdr(input logic [2:0] ad);
		@(posedge clk);
		a <= ad;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 rv = rdata;
	endtask : rdr
	task automatic idle;
		for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		chk("op end", {15'h0, busy}, 16'h0);
	endtask : idle
	// Flash pulse monitor and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (fl.erase) eaddr <= fl.addr;
		if (fl.write) wcnt <= wcnt + 1;
		if (fl.write && fl.addr[5:0] == 6'h3) lastd <= fl.data;
		if (fl.lock) lockd <= fl.data;
		if (halt) hseen <= 1;
		if (cyc == 20000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		por <= 0;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) bs <= 2'(i);
			repeat (3) @(posedge clk);
			#1 chk("boot start", {3'h0, bst}, 16'h2000 - (16'h80 << (3 - i)));
			chk("app end", {3'h0, aend}, 16'h1fff - (16'h80 << (3 - i)));
		end
		@(posedge clk);
		ld <= 1;
		lz <= 16'hc2a5;
		@(posedge clk);
		ld <= 0;
		#1 chk("load", {2'h0, lo}, 16'h02a5);
		rdr(3'h7);
		chk("unmapped", {8'h0, rv}, 16'h0);
		z <= 16'hc280;
		wrr(3'h0, 8'h03, 1);
		repeat (3) @(posedge clk);
		rdr(3'h0);
		chk("ctrl busy", {8'h0, rv & 8'h41}, 16'h41);
		chk("erase addr", {3'h0, eaddr}, 16'h0140);
		@(posedge clk) fa <= 13'h1bff;
		#1 chk("rww fetch", {15'h0, fb}, 16'h1);
		@(posedge clk) fa <= 13'h1c00;
		#1 chk("no_read_while_write_region fetch", {15'h0, fb}, 16'h0);
		idle();
		rdr(3'h0);
		chk("ctrl done", {8'h0, rv & 8'h41}, 16'h40);
		wrr(3'h0, 8'h11, 1);
		repeat (3) @(posedge clk);
		rdr(3'h0);
		chk("reenable", {8'h0, rv & 8'h41}, 16'h0);
		z <= 16'h3886;
		dat <= 16'h1234;
		wrr(3'h0, 8'h01, 1);
		repeat (4) @(posedge clk);
		z <= 16'h3880;
		wrr(3'h0, 8'h05, 1);
		// System reset lands in the middle of the page stream
		repeat (30) @(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		#1 chk("op survives", {15'h0, busy}, 16'h1);
		idle();
		chk("write count", 16'(wcnt), 16'd64);
		chk("word data", lastd, 16'h1234);
		chk("halt", {15'h0, hseen}, 16'h1);
		rdr(3'h0);
		chk("no_read_while_write_region flag", {8'h0, rv & 8'h40}, 16'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			sl <= (i == 0);
			ee <= (i == 1);
			lag <= (i == 2) ? 3'h5 : 3'h1;
			wrr(3'h0, 8'h03, 1);
			repeat (8) @(posedge clk);
			#1 chk("refused", {15'h0, busy}, 16'h0);
		end
		lag <= 3'h1;
		dat <= 16'h00c3;
		wrr(3'h0, 8'h09, 1);
		repeat (3) @(posedge clk);
		rdr(3'h1);
		chk("status", {8'h0, rv}, 16'h000d);
		rdr(3'h2);
		chk("boot lo", {8'h0, rv}, 16'h0080);
		rdr(3'h3);
		chk("boot hi", {8'h0, rv}, 16'h001f);
		idle();
		chk("lock data", lockd, 16'h00c3);
		conclude();
	end
endmodule : tb_fsp_self_prog
